// file: hw/mipc_pkg.sv
/*
  Shared constants and types of the maskable interrupt priority control block.
  Assumes a single 20 MHz system clock and an AHB-Lite register bus.
*/
package mipc_pkg;
  localparam int          NUM_SRC        = 32;
  localparam int          SRC_W          = 5;
  localparam int          LVL_W          = 3;
  localparam logic [2:0]  LVL_OFF        = 3'h0;
  localparam logic [2:0]  LVL_MAX        = 3'h7;
  localparam logic [7:0]  SOFT_LO        = 8'h20;
  localparam logic [7:0]  SOFT_HI        = 8'h3F;
  // Byte offsets
  localparam logic [11:0] OFS_CTRL_BASE  = 12'h000;
  localparam logic [11:0] OFS_FLAGS      = 12'h080;
  localparam logic [11:0] OFS_TEMP       = 12'h084;
  localparam logic [11:0] OFS_SEQ        = 12'h088;
  localparam logic [11:0] OFS_VECBASE    = 12'h08C;
  // Source control word fields
  localparam int          CTL_LVL_LSB    = 0;
  localparam int          CTL_PEND_BIT   = 3;
  localparam int          CTL_POL_BIT    = 4;
  // Flag word fields
  localparam int          FLG_D_BIT      = 2;
  localparam int          FLG_I_BIT      = 6;
  localparam int          FLG_U_BIT      = 7;
  localparam int          FLG_IPL_LSB    = 12;
  localparam logic [15:0] FLG_RESET      = 16'h0000;
  localparam logic [31:0] VEC_RESET      = 32'h0000_0000;
  // Special interrupt numbers used on the core request port
  localparam logic [7:0]  NUM_WDT        = 8'hF0;
  localparam logic [7:0]  NUM_NMI        = 8'hF1;
  localparam logic [7:0]  NUM_AMATCH     = 8'hF2;
  localparam logic [7:0]  NUM_DBG        = 8'hF3;
  localparam logic [7:0]  NUM_STEP       = 8'hF4;
  localparam logic [7:0]  SRC_NUM_BASE   = 8'h00;

  typedef enum logic [6:0] {
    SEQ_IDLE  = 7'b0000001,
    SEQ_INFO  = 7'b0000010,
    SEQ_SAVE  = 7'b0000100,
    SEQ_FLAGS = 7'b0001000,
    SEQ_PSHF  = 7'b0010000,
    SEQ_PSHPC = 7'b0100000,
    SEQ_VEC   = 7'b1000000
  } mipc_seq_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  num;
    logic [2:0]  lvl;
  } mipc_req_type;

  typedef struct packed {
    logic        push;
    logic        pushPc;
    logic [15:0] data;
    logic        loadPc;
    logic [31:0] pc;
    logic        resume;
  } mipc_core_type;
endpackage

// file: hw/mipc_arbiter.sv
/*
  Fixed order priority arbiter for maskable sources.
  Gates each request itself by pending bit, level above the threshold and the enable flag.
*/
`timescale 1ns/1ps
module mipc_arbiter
  import mipc_pkg::*;
(
  input  wire logic [mipc_pkg::NUM_SRC-1:0]         pend,
  input  wire logic [mipc_pkg::NUM_SRC*3-1:0]       lvls,
  input  wire logic [2:0]                           processor_priority_level,
  input  wire logic                                 iFlag,
  output mipc_pkg::mipc_req_type                    win
);
  function automatic mipc_req_type pick(input logic [NUM_SRC-1:0] p, input logic [NUM_SRC*3-1:0] l,
                                        input logic [2:0] thr, input logic en);
    mipc_req_type r;
    logic [2:0]   lv;
    r = '0;
    // Lower index wins among equal levels
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      lv = l[i*3 +: 3];
      if (en && p[i] && lv > thr && (!r.valid || lv >= r.lvl)) begin
        r.valid = 1'b1;
        r.lvl   = lv;
        r.num   = SRC_NUM_BASE + 8'(i);
      end
    end
    return r;
  endfunction

  assign win = pick(pend, lvls, processor_priority_level, iFlag);
endmodule

// file: hw/mipc_flagsave.sv
/*
  Flag adjust logic for entry into the interrupt sequence.
  Assumes the flag word layout given by the package.
*/
`timescale 1ns/1ps
module mipc_flagsave
  import mipc_pkg::*;
(
  input  wire logic [15:0] flags,
  input  wire logic [7:0]  num,
  output logic      [15:0] adj
);
  wire keepU = (num >= SOFT_LO) && (num <= SOFT_HI);
  always_comb begin
    adj = flags;
    adj[FLG_I_BIT] = 1'b0;
    adj[FLG_D_BIT] = 1'b0;
    if (!keepU) begin
      adj[FLG_U_BIT] = 1'b0;
    end
  end
endmodule

// file: hw/mipc_ctrl.sv
/*
  Maskable interrupt priority control with the interrupt entry sequence.
  Assumes an AHB-Lite master, peripheral request pulses on srcReq, and a core
  that flags instruction boundaries and interruptible string instructions.
*/
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module mipc_ctrl
  import mipc_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire logic [mipc_pkg::NUM_SRC-1:0]    srcReq,
  input  wire logic                            instrDone,
  input  wire logic                            strInstr,
  input  wire logic                            specReq,
  input  wire logic [7:0]                      specNum,
  input  wire logic [31:0]                     curPc,
  output logic                                 seqBusy,
  output logic                                 stallCore,
  output logic                                 pushStrobe,
  output logic                                 pushIsPc,
  output logic      [15:0]                     pushData,
  output logic                                 pcLoad,
  output logic      [31:0]                     pcValue,
  output logic                                 resumeCore,
  output logic      [7:0]                      ackNum,
  output logic      [2:0]                      ackLvl
);
  logic                 rstS1_q, rstS2_q;
  wire                  rstN = rstS2_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstS1_q <= 1'b0;
      rstS2_q <= 1'b0;
    end else begin
      rstS1_q <= 1'b1;
      rstS2_q <= rstS1_q;
    end
  end

  // Storage
  logic [NUM_SRC-1:0]   pend_q;
  logic [NUM_SRC-1:0]   pol_q;
  logic [NUM_SRC*3-1:0] lvl_q;
  logic [15:0]          flags_q;
  logic [15:0]          temp_q;
  logic [31:0]          vecBase_q;
  mipc_seq_type         seq_q;
  mipc_req_type         cur_q;
  logic                 special_q;

  // AHB address phase capture
  logic                 wrPend_q, rdPend_q;
  logic [11:0]          addr_q;
  logic [31:0]          rdata_q;

  wire        xfer     = hsel && hready && htrans[1];
  wire [11:0] aOfs     = haddr[11:0];
  wire        wrCtl    = wrPend_q && (addr_q < OFS_FLAGS);
  wire [4:0]  wrIdx    = addr_q[6:2];
  wire        wrFlags  = wrPend_q && (addr_q == OFS_FLAGS);
  wire        wrVec    = wrPend_q && (addr_q == OFS_VECBASE);

  function automatic logic [31:0] readReg(input logic [11:0] a);
    logic [4:0] i;
    i = a[6:2];
    if (a < OFS_FLAGS) begin
      return {27'h0, pol_q[i], pend_q[i], lvl_q[i*3 +: 3]};
    end
    unique case (a)
      OFS_FLAGS:   return {16'h0, flags_q};
      OFS_TEMP:    return 32'h0;                 // Hidden from software
      OFS_SEQ:     return {16'h0, cur_q.num, 1'b0, cur_q.lvl, 3'h0, seq_q != SEQ_IDLE};
      OFS_VECBASE: return vecBase_q;
      default:     return 32'h0;
    endcase
  endfunction

  // Arbitration
  mipc_req_type win;
  logic [15:0]  flagsAdj;

  mipc_arbiter u_arb (
    .pend  (pend_q),
    .lvls  (lvl_q),
    .processor_priority_level   (flags_q[FLG_IPL_LSB +: 3]),
    .iFlag (flags_q[FLG_I_BIT]),
    .win   (win)
  );

  mipc_flagsave u_fs (
    .flags (flags_q),
    .num   (cur_q.num),
    .adj   (flagsAdj)
  );

  wire boundary   = instrDone || strInstr;
  wire takeSpec   = (seq_q == SEQ_IDLE) && boundary && specReq;
  wire takeMask   = (seq_q == SEQ_IDLE) && boundary && !specReq && win.valid;
  wire specSeven  = (specNum == NUM_WDT) || (specNum == NUM_NMI);
  wire [2:0] newIpl = special_q ? (cur_q.lvl) : cur_q.lvl;
  wire        keepIpl = special_q && (cur_q.lvl == LVL_OFF);

  mipc_seq_type seqNext;
  always_comb begin
    seqNext = seq_q;
    unique case (seq_q)
      SEQ_IDLE:  if (takeSpec || takeMask) seqNext = SEQ_INFO;
      SEQ_INFO:  seqNext = SEQ_SAVE;
      SEQ_SAVE:  seqNext = SEQ_FLAGS;
      SEQ_FLAGS: seqNext = SEQ_PSHF;
      SEQ_PSHF:  seqNext = SEQ_PSHPC;
      SEQ_PSHPC: seqNext = SEQ_VEC;
      SEQ_VEC:   seqNext = SEQ_IDLE;
      default:   seqNext = SEQ_IDLE;
    endcase
  end

  // Pending clear from the sequence, from software, and set from sources
  wire [NUM_SRC-1:0] seqClr = (seq_q == SEQ_INFO && !special_q) ?
                              (NUM_SRC'(1) << cur_q.num[4:0]) : '0;
  wire [NUM_SRC-1:0] swClr  = (wrCtl && !hwdata[CTL_PEND_BIT]) ?
                              (NUM_SRC'(1) << wrIdx) : '0;
  wire [NUM_SRC-1:0] pendD  = ((pend_q & ~seqClr & ~swClr)) | srcReq;    // Set wins

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pend_q    <= '0;
      lvl_q     <= '0;
      pol_q     <= '0;
      flags_q   <= FLG_RESET;
      temp_q    <= 16'h0000;
      vecBase_q <= VEC_RESET;
      seq_q     <= SEQ_IDLE;
      cur_q     <= '0;
      special_q <= 1'b0;
    end else begin
      pend_q <= pendD;
      seq_q  <= seqNext;
      if (wrCtl) begin
        lvl_q[wrIdx*3 +: 3] <= hwdata[CTL_LVL_LSB +: 3];
        pol_q[wrIdx]        <= hwdata[CTL_POL_BIT];
      end
      if (wrVec) begin
        vecBase_q <= hwdata;
      end
      if (takeSpec) begin
        cur_q     <= '{valid: 1'b1, num: specNum, lvl: specSeven ? LVL_MAX : LVL_OFF};
        special_q <= 1'b1;
      end else if (takeMask) begin
        cur_q     <= win;
        special_q <= 1'b0;
      end
      if (seq_q == SEQ_SAVE) begin
        temp_q <= flags_q;
      end
      if (seq_q == SEQ_FLAGS) begin
        flags_q <= flagsAdj;
      end else if (seq_q == SEQ_VEC && !keepIpl) begin
        flags_q[FLG_IPL_LSB +: 3] <= newIpl;
      end else if (wrFlags) begin
        flags_q <= hwdata[15:0];
      end
    end
  end

  // Bus and core outputs, all registered
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wrPend_q   <= 1'b0;
      rdPend_q   <= 1'b0;
      addr_q     <= 12'h000;
      rdata_q    <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      seqBusy    <= 1'b0;
      stallCore  <= 1'b0;
      pushStrobe <= 1'b0;
      pushIsPc   <= 1'b0;
      pushData   <= 16'h0000;
      pcLoad     <= 1'b0;
      pcValue    <= 32'h0;
      resumeCore <= 1'b0;
      ackNum     <= 8'h00;
      ackLvl     <= 3'h0;
    end else begin
      wrPend_q   <= xfer && hwrite;
      rdPend_q   <= xfer && !hwrite;
      if (xfer) begin
        addr_q <= aOfs;
      end
      if (xfer && !hwrite) begin
        rdata_q <= readReg(aOfs);
      end
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      seqBusy    <= seqNext != SEQ_IDLE;
      stallCore  <= seqNext != SEQ_IDLE;
      pushStrobe <= (seq_q == SEQ_FLAGS) || (seq_q == SEQ_PSHF);
      pushIsPc   <= seq_q == SEQ_PSHF;
      pushData   <= (seq_q == SEQ_PSHF) ? curPc[15:0] : temp_q;
      pcLoad     <= seq_q == SEQ_VEC;
      pcValue    <= vecBase_q + {22'h0, cur_q.num, 2'b00};
      resumeCore <= seq_q == SEQ_VEC;
      if (seq_q == SEQ_INFO) begin
        ackNum <= cur_q.num;
        ackLvl <= cur_q.lvl;
      end
    end
  end

  assign hrdata = rdata_q;

  a_gate_enable: assert property (@(posedge clk_sys) disable iff (!rstN)
    takeMask |-> flags_q[FLG_I_BIT] && win.lvl > flags_q[FLG_IPL_LSB +: 3])
    else $error("maskable taken while gated");
  // Entry and exit steps of the interrupt sequence
  sequence s_entry;
    seq_q == SEQ_INFO ##1 seq_q == SEQ_SAVE ##1 seq_q == SEQ_FLAGS;
  endsequence
  sequence s_exit;
    seq_q == SEQ_PSHF ##1 seq_q == SEQ_PSHPC ##1 seq_q == SEQ_VEC;
  endsequence

  a_seq_len: assert property (@(posedge clk_sys) disable iff (!rstN)
    (takeMask || takeSpec) |=> s_entry ##1 s_exit ##1 seq_q == SEQ_IDLE)
    else $error("sequence length wrong");
  a_gate_off: assert property (@(posedge clk_sys) disable iff (!rstN)
    !flags_q[FLG_I_BIT] |-> !takeMask)
    else $error("maskable taken while disabled");
  a_level_zero: assert property (@(posedge clk_sys) disable iff (!rstN)
    takeMask |-> win.lvl != LVL_OFF)
    else $error("level zero source taken");
  a_ipl_block: assert property (@(posedge clk_sys) disable iff (!rstN)
    flags_q[FLG_IPL_LSB +: 3] == LVL_MAX |-> !win.valid)
    else $error("threshold seven did not block");
  a_ack_info: assert property (@(posedge clk_sys) disable iff (!rstN)
    seq_q == SEQ_INFO |=> ackNum == $past(cur_q.num) && ackLvl == $past(cur_q.lvl))
    else $error("interrupt info not presented");
  a_keep_user: assert property (@(posedge clk_sys) disable iff (!rstN)
    (seq_q == SEQ_FLAGS && cur_q.num >= SOFT_LO && cur_q.num <= SOFT_HI) |=> flags_q[FLG_U_BIT] == $past(flags_q[FLG_U_BIT]))
    else $error("stack select changed for software number");
  a_vec_load: assert property (@(posedge clk_sys) disable iff (!rstN)
    seq_q == SEQ_VEC |=> pcLoad && resumeCore)
    else $error("vector load missing");
  a_nmi_seven: assert property (@(posedge clk_sys) disable iff (!rstN)
    (seq_q == SEQ_VEC && special_q && (cur_q.num == NUM_WDT || cur_q.num == NUM_NMI)) |=> flags_q[FLG_IPL_LSB +: 3] == LVL_MAX)
    else $error("threshold not raised to seven");
  a_ipl_keep: assert property (@(posedge clk_sys) disable iff (!rstN)
    (seq_q == SEQ_VEC && special_q && cur_q.num != NUM_WDT && cur_q.num != NUM_NMI && !wrFlags) |=> $stable(flags_q[FLG_IPL_LSB +: 3]))
    else $error("threshold changed by special entry");
  a_spec_ungated: assert property (@(posedge clk_sys) disable iff (!rstN)
    (seq_q == SEQ_IDLE && boundary && specReq) |=> seq_q == SEQ_INFO)
    else $error("nonmaskable request not taken");
  a_pend_clear: assert property (@(posedge clk_sys) disable iff (!rstN)
    (seq_q == SEQ_INFO && !special_q && !srcReq[cur_q.num[4:0]]) |=> !pend_q[$past(cur_q.num[4:0])])
    else $error("pending not cleared");
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rstN)
    seq_q == SEQ_FLAGS |=> !flags_q[FLG_I_BIT] && !flags_q[FLG_D_BIT])
    else $error("flags not cleared");
  a_push_order: assert property (@(posedge clk_sys) disable iff (!rstN)
    (pushStrobe && !pushIsPc) |=> pushStrobe && pushIsPc)
    else $error("push order wrong");
  a_ipl_set: assert property (@(posedge clk_sys) disable iff (!rstN)
    (seq_q == SEQ_VEC && !special_q) |=> flags_q[FLG_IPL_LSB +: 3] == $past(cur_q.lvl))
    else $error("threshold not updated");
  a_temp_save: assert property (@(posedge clk_sys) disable iff (!rstN)
    seq_q == SEQ_SAVE |=> temp_q == $past(flags_q))
    else $error("flags copy wrong");
  a_set_wins: assert property (@(posedge clk_sys) disable iff (!rstN)
    srcReq != '0 |=> (pend_q & $past(srcReq)) == $past(srcReq))
    else $error("request lost");
endmodule

// file: bench/mipc_core_model.sv
/*
  Core side model: instruction-end pulses, program counter, capture of the
  two stack pushes. Assumes the block's push and load strobes last one cycle.
*/
`timescale 1ns/1ps
module mipc_core_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        strMode,
  input  wire logic        stallCore,
  input  wire logic        pushStrobe,
  input  wire logic        pushIsPc,
  input  wire logic [15:0] pushData,
  input  wire logic        pcLoad,
  input  wire logic [31:0] pcValue,
  output logic             instrDone,
  output logic             strInstr,
  output logic      [31:0] curPc,
  output logic      [15:0] flgPush,
  output logic      [15:0] pcPush,
  output logic             orderBad
);
  logic [1:0] cnt_q;
  logic       sawFlg_q;
  assign strInstr  = strMode;
  // Every third cycle ends an instruction, never while stalled or looping
  assign instrDone = (cnt_q == 2'h2) && !stallCore && !strMode;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      curPc <= 32'h0000_0100;
      flgPush <= 16'h0;
      pcPush <= 16'h0;
      sawFlg_q <= 1'b0;
      orderBad <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      if (pcLoad) begin
        curPc <= pcValue;
      end else if (instrDone) begin
        curPc <= curPc + 32'h2;
      end
      if (pushStrobe && !pushIsPc) begin
        flgPush <= pushData;
        sawFlg_q <= 1'b1;
      end
      // A PC push with no flag push before it is out of order
      if (pushStrobe && pushIsPc) begin
        pcPush <= pushData;
        orderBad <= orderBad | !sawFlg_q;
        sawFlg_q <= 1'b0;
      end
    end
  end
endmodule

// file: bench/tb.sv
/*
  Self-checking bench for the interrupt priority control block.
  Assumes the core model is compiled first; 20 MHz clock, AHB-Lite master.
*/
`timescale 1ns/1ps
module tb;
  import mipc_pkg::*;
  logic        clk_sys = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        strMode = 1'b0, specReq = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, srcReq = 32'h0;
  logic [7:0]  specNum = 8'h0;
  wire  logic  hready;
  logic [31:0] hrdata, pcValue, curPc;
  logic        hreadyout, hresp, seqBusy, stallCore, pushStrobe, pushIsPc;
  logic        pcLoad, resumeCore, instrDone, strInstr, orderBad;
  logic [15:0] pushData, flgPush, pcPush;
  logic [7:0]  ackNum;
  logic [2:0]  ackLvl;
  int          miscompares = 0, checked = 0, cycles = 0;
  assign hready = hreadyout;
  always #25 clk_sys = ~clk_sys;
  mipc_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .srcReq(srcReq), .instrDone(instrDone),
    .strInstr(strInstr), .specReq(specReq), .specNum(specNum), .curPc(curPc),
    .seqBusy(seqBusy), .stallCore(stallCore), .pushStrobe(pushStrobe), .pushIsPc(pushIsPc),
    .pushData(pushData), .pcLoad(pcLoad), .pcValue(pcValue), .resumeCore(resumeCore),
    .ackNum(ackNum), .ackLvl(ackLvl));
  mipc_core_model core (.clk_sys(clk_sys), .nrst(nrst), .strMode(strMode),
    .stallCore(stallCore), .pushStrobe(pushStrobe), .pushIsPc(pushIsPc),
    .pushData(pushData), .pcLoad(pcLoad), .pcValue(pcValue), .instrDone(instrDone),
    .strInstr(strInstr), .curPc(curPc), .flgPush(flgPush), .pcPush(pcPush),
    .orderBad(orderBad));
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic pulse(input logic [31:0] m);
    srcReq <= m;
    @(posedge clk_sys);
    srcReq <= 32'h0;
    @(posedge clk_sys);
  endtask
  task automatic spec(input logic [7:0] num);
    int k;
    k = 0;
    specNum <= num;
    specReq <= 1'b1;
    while (seqBusy !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    specReq <= 1'b0;
  endtask
  // Waits for the vector load; a missing or unwanted entry is a mismatch
  task automatic seq(input logic hit, input logic [7:0] n, input logic [31:0] pv);
    int k;
    logic [31:0] pc0;
    k = 0;
    pc0 = 32'h0;
    while (pcLoad !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      if (seqBusy === 1'b1 && pc0 == 32'h0) pc0 = curPc;
      k++;
    end
    chk({31'h0, k < 40}, {31'h0, hit});
    if (hit) begin
      chk({31'h0, resumeCore}, 32'h1);
      chk({24'h0, ackNum}, {24'h0, n});
      chk(pcValue, pv);
      chk({16'h0, pcPush}, {16'h0, pc0[15:0]});
      chk({31'h0, orderBad}, 32'h0);
    end
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rchk(OFS_CTRL_BASE, 32'h0);
    rchk(12'h07C, 32'h0);
    rchk(12'h00C, 32'h0);
    wr(OFS_VECBASE, 32'h0000_1000);
    wr(12'h014, 32'h3);
    pulse(32'h20);
    seq(1'b0, 8'h0, 32'h0);
    rchk(12'h014, 32'hB);
    wr(OFS_FLAGS, 32'h3040);
    rchk(12'h014, 32'hB);
    seq(1'b0, 8'h0, 32'h0);
    wr(12'h014, 32'h3);
    rchk(12'h014, 32'h3);
    wr(OFS_FLAGS, 32'h0040);
    pulse(32'h80);
    seq(1'b0, 8'h0, 32'h0);
    wr(12'h018, 32'h4);
    rchk(12'h018, 32'h4);
    wr(12'h020, 32'h4);
    wr(12'h024, 32'h4);
    wr(OFS_FLAGS, 32'h30C4);
    pulse(32'h300);
    seq(1'b1, 8'h08, 32'h0000_1020);
    chk({29'h0, ackLvl}, 32'h4);
    chk({16'h0, flgPush}, 32'h30C4);
    rchk(OFS_FLAGS, 32'h4000);
    rchk(12'h020, 32'h4);
    rchk(12'h024, 32'hC);
    wr(12'h024, 32'h4);
    wr(OFS_FLAGS, 32'h4084);
    spec(SOFT_LO);
    seq(1'b1, SOFT_LO, 32'h0000_1080);
    chk({16'h0, flgPush}, 32'h4084);
    rchk(OFS_FLAGS, 32'h4080);
    wr(OFS_FLAGS, 32'h0000);
    strMode <= 1'b1;
    spec(NUM_NMI);
    seq(1'b1, NUM_NMI, 32'h0000_13C4);
    strMode <= 1'b0;
    rchk(OFS_FLAGS, 32'h7000);
    spec(NUM_DBG);
    seq(1'b1, NUM_DBG, 32'h0000_13CC);
    rchk(OFS_FLAGS, 32'h7000);
    print_verdict();
  end
endmodule
